// File: rtl/cwlc_bank.sv
// Register bank for the password lock, reserved registers and config checksum.
// Assumes the serial front end presents one decoded access per cycle on i_req.
// Assumes the master clock run level is already synchronous to i_clk.
// Assumes i_cfg_lo stands in for the lower configuration map in the checksum.
// Operation
// - Reserved byte at 0xC resets to 0x50; host keeps writing 0x50.
// - With password 0xA5 all map locations except the checksum at 0xF accept writes.
// - With password 0xA5 no checksum runs and checksum reads 0x0000.
// - Locked: only the password register accepts writes.
// - Locked: checksum recomputes each cycle the master clock enable runs.
// - Read-only 16-bit CRC-16 at 0xF, resets to zero, writes ignored.
// - Password register at 0xD resets to 0xA5, map unlocked.
// - Reserved word at 0xE holds variant value 0x000C, 0x000D or 0x000F.
// - Commands act only when command bits 7:6 match device address.
// - Checksum error flag goes low on mismatch and stays low until unlock, high otherwise.
`timescale 1ns/1ns
`default_nettype none
module cwlc_bank #(
    parameter logic [15:0] P_RSV_E_RESET = cwlc_pkg::RSV_E_RESET,
    parameter logic [1:0] P_DEV_ADDR = cwlc_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_digital_master_clock_run,
    input wire cwlc_pkg::cwlc_req_t i_req,
    input wire logic [7:0] i_cfg_lo,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    output logic o_locked,
    output logic [15:0] o_config_checksum,
    output logic o_checksum_error_flag
);
    // ==========================================
    // Storage
    logic [7:0] rsv_c_q;
    logic [7:0] pass_q;
    logic [15:0] rsv_e_q;
    logic [15:0] crc_q;
    logic [15:0] ref_q;
    logic ref_valid_q;
    logic err_n_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic locked_d;
    logic locked_q;
    logic hit;
    logic wr_ok;
    logic [15:0] crc_d;

    // One CRC-16 step over a byte, MSB first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int k = 7; k >= 0; k--) begin
            if (r[15] ^ b[k]) begin
                r = {r[14:0], 1'b0} ^ cwlc_pkg::CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Address match and write permission
    assign hit = (i_req.cmd[cwlc_pkg::CMD_ADDR_MSB:cwlc_pkg::CMD_ADDR_LSB] == P_DEV_ADDR);
    assign locked_d = (pass_q != cwlc_pkg::UNLOCK_KEY);
    assign wr_ok = hit && i_req.wr && (!locked_d || i_req.addr == cwlc_pkg::ADDR_PASSWORD);

    // Checksum over the configuration settings
    always_comb begin
        crc_d = cwlc_pkg::CRC_SEED;
        crc_d = crc_byte(crc_d, i_cfg_lo);
        crc_d = crc_byte(crc_d, rsv_c_q);
        crc_d = crc_byte(crc_d, pass_q);
        crc_d = crc_byte(crc_d, rsv_e_q[15:8]);
        crc_d = crc_byte(crc_d, rsv_e_q[7:0]);
    end

    // Password register and its registered lock state
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pass_q <= cwlc_pkg::UNLOCK_KEY;
            locked_q <= 1'b0;
        end else if (wr_ok && i_req.addr == cwlc_pkg::ADDR_PASSWORD) begin
            pass_q <= i_req.wdata[7:0];
            locked_q <= (i_req.wdata[7:0] != cwlc_pkg::UNLOCK_KEY);
        end
    end

    // Reserved registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rsv_c_q <= cwlc_pkg::RSV_C_RESET;
            rsv_e_q <= P_RSV_E_RESET;
        end else if (wr_ok) begin
            if (i_req.addr == cwlc_pkg::ADDR_RSV_C) begin
                rsv_c_q <= i_req.wdata[7:0];
            end
            if (i_req.addr == cwlc_pkg::ADDR_RSV_E) begin
                rsv_e_q <= i_req.wdata;
            end
        end
    end

    // Running checksum, held at zero while unlocked
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            crc_q <= cwlc_pkg::CHECKSUM_RESET;
        end else if (!locked_d) begin
            crc_q <= cwlc_pkg::CHECKSUM_RESET;
        end else if (i_digital_master_clock_run) begin
            crc_q <= crc_d;
        end
    end

    // Reference capture and mismatch flag; error is sticky until unlock
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ref_q <= cwlc_pkg::CHECKSUM_RESET;
            ref_valid_q <= 1'b0;
            err_n_q <= 1'b1;
        end else if (!locked_d) begin
            ref_valid_q <= 1'b0;
            err_n_q <= 1'b1;
        end else if (i_digital_master_clock_run) begin
            if (!ref_valid_q) begin
                ref_q <= crc_d;
                ref_valid_q <= 1'b1;
            end else if (crc_d != ref_q) begin
                err_n_q <= 1'b0;
            end
        end
    end

    // Read port
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= hit && i_req.rd;
            case (i_req.addr)
                cwlc_pkg::ADDR_RSV_C: rdata_q <= {8'h00, rsv_c_q};
                cwlc_pkg::ADDR_PASSWORD: rdata_q <= {8'h00, pass_q};
                cwlc_pkg::ADDR_RSV_E: rdata_q <= rsv_e_q;
                cwlc_pkg::ADDR_CHECKSUM: rdata_q <= crc_q;
                default: rdata_q <= 16'h0000;
            endcase
        end
    end

    // Outputs, each taken from a register
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;
    assign o_locked = locked_q;
    assign o_config_checksum = crc_q;
    assign o_checksum_error_flag = err_n_q;

    // ==========================================
    // Checks
    // Write attempts that the lock must refuse
    sequence s_lock_write;
        hit && i_req.wr && locked_d && i_req.addr == cwlc_pkg::ADDR_RSV_C;
    endsequence
    sequence s_lock_write_e;
        hit && i_req.wr && locked_d && i_req.addr == cwlc_pkg::ADDR_RSV_E;
    endsequence
    // Locked cycle with the master clock stopped, still locked after it
    sequence s_stalled_locked;
        (locked_d && !i_digital_master_clock_run) ##1 locked_d;
    endsequence

    // Lock gate on register writes, lock state, checksum at zero while unlocked
    a_locked_word_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_lock_write_e |=> $stable(rsv_e_q)) else $error("locked write changed word");
    a_unlocked_byte_taken: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (hit && i_req.wr && !locked_d && i_req.addr == cwlc_pkg::ADDR_RSV_C)
        |=> rsv_c_q == $past(i_req.wdata[7:0])) else $error("unlocked byte write lost");
    a_lock_state: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        locked_q == locked_d) else $error("lock state out of step");
    a_locked_write_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_lock_write |=> $stable(rsv_c_q)) else $error("locked write changed register");
    a_unlocked_write_taken: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (hit && i_req.wr && !locked_d && i_req.addr == cwlc_pkg::ADDR_RSV_E)
        |=> rsv_e_q == $past(i_req.wdata)) else $error("unlocked write lost");
    a_unlocked_crc_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !locked_d |=> (crc_q == 16'h0000) || locked_d) else $error("checksum nonzero unlocked");

    // Checksum while locked, and password write
    a_crc_stall_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_stalled_locked |-> $stable(crc_q)) else $error("checksum moved");
    a_crc_run_update: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (locked_d && i_digital_master_clock_run) |=> crc_q == $past(crc_d))
        else $error("checksum not recomputed");
    a_crc_ro_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (hit && i_req.wr && i_req.addr == cwlc_pkg::ADDR_CHECKSUM && locked_d
            && i_digital_master_clock_run) |=> crc_q == $past(crc_d))
        else $error("checksum written");
    a_pass_writable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (hit && i_req.wr && i_req.addr == cwlc_pkg::ADDR_PASSWORD)
        |=> pass_q == $past(i_req.wdata[7:0])) else $error("password write lost");

    // Read port and address filter
    a_addr_filter: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!hit) |=> $stable(pass_q) && !rvalid_q) else $error("foreign command acted on");
    a_read_answer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (hit && i_req.rd) |=> rvalid_q) else $error("read not answered");
    a_rdata_checksum: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (hit && i_req.rd && i_req.addr == cwlc_pkg::ADDR_CHECKSUM)
        |=> rdata_q == $past(crc_q)) else $error("checksum read wrong");

    // Error flag and reference
    a_err_on_diff: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (locked_d && i_digital_master_clock_run && ref_valid_q && crc_d != ref_q)
        |=> !err_n_q || !locked_d) else $error("mismatch not flagged");
    a_err_high_unlock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !locked_d |=> err_n_q) else $error("error flag low while unlocked");
    a_ref_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (locked_d && i_digital_master_clock_run && !ref_valid_q)
        |=> ref_valid_q && ref_q == $past(crc_d))
        else $error("reference not captured");
endmodule
`default_nettype wire

// File: rtl/cwlc_pkg.sv
// Package for the configuration write-lock and checksum register bank.
// Assumes a byte-oriented register access front end decoded from serial command bytes.
package cwlc_pkg;
    // ==========================================
    // Register addresses
    localparam logic [3:0] ADDR_RSV_C = 4'hC;
    localparam logic [3:0] ADDR_PASSWORD = 4'hD;
    localparam logic [3:0] ADDR_RSV_E = 4'hE;
    localparam logic [3:0] ADDR_CHECKSUM = 4'hF;
    // ==========================================
    // Reset and key values
    localparam logic [7:0] RSV_C_RESET = 8'h50;
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;
    localparam logic [15:0] RSV_E_RESET = 16'h000F;
    localparam logic [15:0] CHECKSUM_RESET = 16'h0000;
    localparam logic [1:0] DEV_ADDR_DEFAULT = 2'h1;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_SEED = 16'h0000;
    // Command byte field positions
    localparam int CMD_ADDR_MSB = 7;
    localparam int CMD_ADDR_LSB = 6;
    // ==========================================
    // Register access request
    typedef struct packed {
        logic [7:0] cmd;
        logic [3:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } cwlc_req_t;
endpackage

// File: verif/cwlc_host.sv
// Host controller model that issues decoded register commands to the bank.
// Assumes the bench calls op() from its main sequence; drives on falling edges.
`timescale 1ns/1ns
`default_nettype none
module cwlc_host (
    input wire logic i_clk,
    output var cwlc_pkg::cwlc_req_t o_req
);
    // ==========================================
    // Idle bus before the first access: no strobes, all fields zero
    initial o_req = '0;
    // One access held for one rising edge; command carries device address
    task automatic op(input logic [1:0] da, input logic w, input logic [3:0] a,
                      input logic [15:0] d);
        @(negedge i_clk);
        o_req = '{cmd: {da, 6'h00}, addr: a, wr: w, rd: !w, wdata: d};
        @(negedge i_clk);
        o_req = '{cmd: {~da, 6'h3F}, addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the write-lock and checksum bank.
// Assumes the host model drives requests and a register model predicts reads.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0, rst_n = 1'b0, run = 1'b1, rvalid, locked, flag;
    logic [7:0] cfg = 8'h00;
    logic [15:0] rdata, csum, sd = 16'hB75E, exp_cs;
    logic [15:0] e_vals [3] = '{16'h000C, 16'h000D, 16'h000F};
    int error_cnt = 0, num_checks = 0, m_c = 'h50, m_d = 'hA5, m_e = 'hF;
    cwlc_pkg::cwlc_req_t req;
    // ==========================================
    // Clock, host, design
    initial forever #5 clk = ~clk;
    cwlc_host host_u (.i_clk(clk), .o_req(req));
    cwlc_bank dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_digital_master_clock_run(run), .i_req(req),
        .i_cfg_lo(cfg), .o_rdata(rdata), .o_rvalid(rvalid), .o_locked(locked),
        .o_config_checksum(csum), .o_checksum_error_flag(flag));
    // ==========================================
    // Helpers: random source, checksum model, compare
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] crcm();
        logic [39:0] b;
        logic [15:0] c;
        b = {cfg, m_c[7:0], m_d[7:0], m_e[15:0]};
        c = 16'h0000;
        for (int i = 39; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write through host and update model: gate, address filter, read-only word
    task automatic wr(input logic [1:0] da, input logic [3:0] a, input logic [15:0] d);
        host_u.op(da, 1'b1, a, d);
        if (da == 2'h1 && (m_d == 'hA5 || a == 4'hD)) begin
            if (a == 4'hC) m_c = d[7:0];
            if (a == 4'hD) m_d = d[7:0];
            if (a == 4'hE) m_e = d;
        end
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        host_u.op(2'h1, 1'b0, a, 16'h0000);
        for (int i = 0; i < 3 && rvalid !== 1'b1; i++) @(negedge clk);
        chk({15'h0, rvalid}, 16'h0001);
        chk(rdata, exp);
    endtask
    task automatic rdall();
        rdchk(4'hC, 16'(m_c));
        rdchk(4'hD, 16'(m_d));
        rdchk(4'hE, 16'(m_e));
        rdchk(4'hF, (m_d == 'hA5) ? 16'h0000 : crcm());
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog well beyond the hundred or fewer cycles the tests need
    initial begin
        #50000;
        error_cnt++;
        report_and_stop();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk) rst_n <= 1'b1;
        rdall();
        chk({15'h0, flag}, 16'h0001);
        $display("reset test done");
        foreach (e_vals[i]) begin
            wr(2'h1, 4'hE, e_vals[i]);
            rdchk(4'hE, 16'(m_e));
        end
        wr(2'h1, 4'hC, 16'h0050);
        sd = nxt(sd);
        wr(2'h1, 4'hF, sd);
        wr(2'h2, 4'hE, 16'h000C);
        rdall();
        host_u.op(2'h3, 1'b0, 4'hD, 16'h0000);
        chk({15'h0, rvalid}, 16'h0000);
        $display("unlocked test done");
        sd = nxt(sd);
        wr(2'h1, 4'hD, (sd[7:0] == 8'hA5) ? 16'h005A : {8'h00, sd[7:0]});
        chk({15'h0, locked}, 16'h0001);
        wr(2'h1, 4'hE, 16'h000C);
        repeat (4) @(negedge clk);
        rdall();
        chk({15'h0, flag}, 16'h0001);
        exp_cs = crcm();
        run = 1'b0;
        cfg = cfg ^ (sd[15:8] | 8'h01);
        repeat (4) @(negedge clk);
        chk(csum, exp_cs);
        run = 1'b1;
        repeat (4) @(negedge clk);
        chk(csum, crcm());
        chk({15'h0, flag}, 16'h0000);
        $display("locked test done");
        wr(2'h1, 4'hD, 16'h00A5);
        chk({15'h0, locked}, 16'h0000);
        rdall();
        chk(csum, 16'h0000);
        $display("unlock test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
